// ==== rtl/lpddr_command_decoder.sv ====
`timescale 1ns/1ns
module lpddr_command_decoder #(
  parameter int PRE_CYC = lpddr_cmd_pkg::PRE_CYC_DEF,
  parameter int REF_CYC = lpddr_cmd_pkg::REF_CYC_DEF,
  parameter int MRD_CYC = lpddr_cmd_pkg::MRD_CYC_DEF,
  parameter int BURST_CYC = lpddr_cmd_pkg::BURST_CYC_DEF
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire lpddr_cmd_pkg::cmd_pins_t pins,
  output lpddr_cmd_pkg::cmd_t cmd_ff,
  output lpddr_cmd_pkg::access_t access_ff,
  output logic [lpddr_cmd_pkg::NBANKS-1:0] row_open_ff,
  output logic all_idle_ff,
  output logic read_burst_ff,
  output logic [lpddr_cmd_pkg::BANK_W-1:0] read_bank_ff,
  output logic refresh_busy_ff,
  output logic [lpddr_cmd_pkg::ROW_W-1:0] refresh_row_ff,
  output logic mode_load_ff,
  output logic [lpddr_cmd_pkg::BANK_W-1:0] mode_sel_ff,
  output logic [lpddr_cmd_pkg::ADDR_W-1:0] mode_opcode_ff,
  output logic mode_busy_ff,
  output lpddr_cmd_pkg::dev_mode_t device_mode_ff,
  output logic array_powered_ff,
  output logic arr_wr_en_ff,
  output logic [lpddr_cmd_pkg::BANK_W-1:0] arr_wr_bank_ff,
  output logic [lpddr_cmd_pkg::DQ_W-1:0] arr_wr_data_ff,
  output logic [lpddr_cmd_pkg::NBYTES-1:0] arr_byte_en_ff
);
  import lpddr_cmd_pkg::*;

  cmd_pins_t s1_ff;
  cmd_pins_t s2_ff;
  cmd_t nxt_cmd;
  logic [CNT_W-1:0] ref_cnt_ff;
  logic [CNT_W-1:0] mrd_cnt_ff;
  logic [CNT_W-1:0] rd_cnt_ff;
  logic [CNT_W-1:0] wr_cnt_ff;
  logic [BANK_W-1:0] wr_bank_ff;
  logic [ROW_W-1:0] ref_ctr_ff;
  logic [NBANKS-1:0] bank_open;
  logic [NBANKS-1:0] bank_idle;
  logic [NBYTES-1:0] nxt_byte_en;
  logic [CNT_W-1:0] ref_len_ff;

  // Pins come from outside the clock domain: two flops first
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      s1_ff <= PINS_IDLE;
      s2_ff <= PINS_IDLE;
    end else begin
      s1_ff <= pins;
      s2_ff <= s1_ff;
    end
  end

  // Command decode; in either sleep mode nothing is decoded
  always_comb begin
    nxt_cmd = CMD_NONE;
    if (device_mode_ff == MODE_RUN && !s2_ff.cs_n) begin
      unique case ({s2_ff.ras_n, s2_ff.cas_n, s2_ff.we_n})
        ENC_NOP: nxt_cmd = CMD_NONE;
        ENC_ACT: nxt_cmd = CMD_ACT;
        ENC_RD: nxt_cmd = CMD_RD;
        ENC_WR: nxt_cmd = CMD_WR;
        ENC_BST: begin
          nxt_cmd = s2_ff.cke ? CMD_BST : CMD_DEEP_SLEEP;
        end
        ENC_PRE: begin
          nxt_cmd = s2_ff.addr[AP_BIT] ? CMD_PREA : CMD_PRE;
        end
        ENC_REF: begin
          nxt_cmd = s2_ff.cke ? CMD_REF : CMD_SREF;
        end
        ENC_LMR: nxt_cmd = CMD_LMR;
      endcase
    end
  end

  // Registered command pulse with its bank and address
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      cmd_ff <= CMD_NONE;
      access_ff <= '0;
    end else begin
      cmd_ff <= nxt_cmd;
      access_ff.bank <= s2_ff.bank_select;
      access_ff.addr <= s2_ff.addr;
      access_ff.auto_pre <= s2_ff.addr[AP_BIT];
    end
  end

  // One tracker per bank; the bank is steered from the registered command
  for (genvar b = 0; b < NBANKS; b++) begin : g_bank
    logic hit;
    assign hit = (access_ff.bank == BANK_W'(b));
    lpddr_bank_tracker #(
      .PRE_CYC(PRE_CYC),
      .BURST_CYC(BURST_CYC)
    ) u_bank (
      .core_clk(core_clk),
      .resetn(resetn),
      .act(cmd_ff == CMD_ACT && hit),
      .access_go((cmd_ff == CMD_RD || cmd_ff == CMD_WR) && hit),
      .auto_pre(access_ff.auto_pre),
      .pre(cmd_ff == CMD_PREA || (cmd_ff == CMD_PRE && hit)),
      .row(access_ff.addr),
      .row_open(bank_open[b]),
      .idle(bank_idle[b]),
      .open_row()
    );
  end

  // Bank status to the outside, plus the all-idle summary
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      row_open_ff <= '0;
      all_idle_ff <= 1'b1;
    end else begin
      row_open_ff <= bank_open;
      all_idle_ff <= (&bank_idle) && !refresh_busy_ff &&
        !mode_busy_ff;
    end
  end

  // Read burst tracker; burst stop cuts only the latest read
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      rd_cnt_ff <= '0;
      read_burst_ff <= 1'b0;
      read_bank_ff <= '0;
    end else if (nxt_cmd == CMD_RD) begin
      rd_cnt_ff <= CNT_W'(BURST_CYC - 1);
      read_burst_ff <= 1'b1;
      read_bank_ff <= s2_ff.bank_select;
    end else if (nxt_cmd == CMD_BST) begin
      // Bank tracker is left alone so the page stays open
      rd_cnt_ff <= '0;
      read_burst_ff <= 1'b0;
    end else if (rd_cnt_ff != '0) begin
      rd_cnt_ff <= rd_cnt_ff - 1'b1;
    end else begin
      read_burst_ff <= 1'b0;
    end
  end

  // Write burst beats follow the command by one cycle
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      wr_cnt_ff <= '0;
      wr_bank_ff <= '0;
    end else if (nxt_cmd == CMD_WR) begin
      wr_cnt_ff <= CNT_W'(BURST_CYC);
      wr_bank_ff <= s2_ff.bank_select;
    end else if (wr_cnt_ff != '0) begin
      wr_cnt_ff <= wr_cnt_ff - 1'b1;
    end
  end

  // Per-byte enable is the inverse of its mask
  for (genvar g = 0; g < NBYTES; g++) begin : g_mask
    assign nxt_byte_en[g] = ~s2_ff.byte_write_mask[g];
  end

  // Array write port; a masked byte keeps its old content
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      arr_wr_en_ff <= 1'b0;
      arr_wr_bank_ff <= '0;
      arr_wr_data_ff <= '0;
      arr_byte_en_ff <= '0;
    end else begin
      arr_wr_en_ff <= (wr_cnt_ff != '0) && array_powered_ff;
      arr_wr_bank_ff <= wr_bank_ff;
      arr_wr_data_ff <= s2_ff.wr_data;
      arr_byte_en_ff <= nxt_byte_en;
    end
  end

  // Auto refresh timer: busy for exactly the refresh cycle time
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      ref_cnt_ff <= '0;
      refresh_busy_ff <= 1'b0;
    end else if (nxt_cmd == CMD_REF) begin
      ref_cnt_ff <= CNT_W'(REF_CYC - 1);
      refresh_busy_ff <= 1'b1;
    end else if (ref_cnt_ff != '0) begin
      ref_cnt_ff <= ref_cnt_ff - 1'b1;
    end else begin
      refresh_busy_ff <= 1'b0;
    end
  end

  // Internal refresh row counter; address pins play no part
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      ref_ctr_ff <= '0;
      refresh_row_ff <= '0;
    end else if (nxt_cmd == CMD_REF) begin
      refresh_row_ff <= ref_ctr_ff;
      ref_ctr_ff <= ref_ctr_ff + 1'b1;
    end
  end

  // Mode register load: one pulse, then the load wait
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      mode_load_ff <= 1'b0;
      mode_sel_ff <= '0;
      mode_opcode_ff <= '0;
    end else begin
      mode_load_ff <= (nxt_cmd == CMD_LMR);
      if (nxt_cmd == CMD_LMR) begin
        mode_sel_ff <= s2_ff.bank_select;
        mode_opcode_ff <= s2_ff.addr;
      end
    end
  end

  // Load wait timer; the controller is trusted to send no-ops meanwhile
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      mrd_cnt_ff <= '0;
      mode_busy_ff <= 1'b0;
    end else if (nxt_cmd == CMD_LMR) begin
      mrd_cnt_ff <= CNT_W'(MRD_CYC - 1);
      mode_busy_ff <= 1'b1;
    end else if (mrd_cnt_ff != '0) begin
      mrd_cnt_ff <= mrd_cnt_ff - 1'b1;
    end else begin
      mode_busy_ff <= 1'b0;
    end
  end

  // Power modes; only clock enable is watched while asleep
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      device_mode_ff <= MODE_RUN;
    end else begin
      unique case (device_mode_ff)
        MODE_RUN: begin
          if (nxt_cmd == CMD_SREF) begin
            device_mode_ff <= MODE_SELF_REFRESH;
          end else if (nxt_cmd == CMD_DEEP_SLEEP) begin
            device_mode_ff <= MODE_DEEP_SLEEP;
          end
        end
        MODE_SELF_REFRESH: begin
          if (s2_ff.cke) begin
            device_mode_ff <= MODE_RUN;
          end
        end
        MODE_DEEP_SLEEP: begin
          if (s2_ff.cke) begin
            device_mode_ff <= MODE_RUN;
          end
        end
        default: device_mode_ff <= MODE_RUN;
      endcase
    end
  end

  // Array power drops in deep sleep; content is then undefined
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      array_powered_ff <= 1'b1;
    end else if (nxt_cmd == CMD_DEEP_SLEEP) begin
      array_powered_ff <= 1'b0;
    end else if (device_mode_ff == MODE_DEEP_SLEEP && s2_ff.cke) begin
      array_powered_ff <= 1'b1;
    end
  end

  // Helper: length of the refresh busy window
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      ref_len_ff <= '0;
    end else begin
      ref_len_ff <= refresh_busy_ff ? ref_len_ff + 1'b1 : '0;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  sequence s_strobes(logic [2:0] enc);
    !s2_ff.cs_n && {s2_ff.ras_n, s2_ff.cas_n, s2_ff.we_n} == enc &&
      device_mode_ff == MODE_RUN;
  endsequence

  sequence s_read_open;
    cmd_ff == CMD_RD && !access_ff.auto_pre;
  endsequence

  a_nop_idle: assert property (
    (s2_ff.cs_n or s_strobes(ENC_NOP)) |=> cmd_ff == CMD_NONE)
    else $error("command decoded while deselected");

  a_act_decode: assert property (
    s_strobes(ENC_ACT) |=> cmd_ff == CMD_ACT &&
      access_ff.bank == $past(s2_ff.bank_select))
    else $error("active decode wrong");

  a_read_decode: assert property (
    s_strobes(ENC_RD) |=> cmd_ff == CMD_RD && read_burst_ff &&
      read_bank_ff == $past(s2_ff.bank_select))
    else $error("read decode wrong");

  a_write_decode: assert property (
    s_strobes(ENC_WR) |=> cmd_ff == CMD_WR ##1 arr_wr_en_ff)
    else $error("write decode wrong");

  a_bst_by_cke: assert property (
    s_strobes(ENC_BST) |=>
      cmd_ff == ($past(s2_ff.cke) ? CMD_BST : CMD_DEEP_SLEEP))
    else $error("burst stop or deep sleep decode wrong");

  a_bst_truncate: assert property (
    (s_read_open ##1 cmd_ff == CMD_BST) |-> !read_burst_ff
      ##3 row_open_ff[read_bank_ff] == $past(row_open_ff[read_bank_ff]))
    else $error("burst stop did not cut the read");

  a_pre_all: assert property (
    (s_strobes(ENC_PRE) and s2_ff.addr[AP_BIT]) |=> cmd_ff == CMD_PREA)
    else $error("precharge all not decoded");

  a_refresh_cke: assert property (
    (s_strobes(ENC_REF) and !s2_ff.cke) |=>
      cmd_ff == CMD_SREF && device_mode_ff == MODE_SELF_REFRESH)
    else $error("self refresh entry wrong");

  a_refresh_len: assert property (
    $fell(refresh_busy_ff) |-> ref_len_ff == CNT_W'(REF_CYC))
    else $error("refresh window length wrong");

  a_refresh_row: assert property (
    cmd_ff == CMD_REF |->
      ref_ctr_ff == refresh_row_ff + 1'b1)
    else $error("refresh row did not advance");

  a_mode_load: assert property (
    s_strobes(ENC_LMR) |=> mode_load_ff && mode_busy_ff &&
      mode_opcode_ff == $past(s2_ff.addr))
    else $error("mode load wrong");

  a_sleep_ignores: assert property (
    device_mode_ff == MODE_SELF_REFRESH && !s2_ff.cke |=>
      cmd_ff == CMD_NONE && device_mode_ff == MODE_SELF_REFRESH)
    else $error("input acted on in self refresh");

  a_deep_power: assert property (
    cmd_ff == CMD_DEEP_SLEEP |-> !array_powered_ff && !arr_wr_en_ff)
    else $error("array powered in deep sleep");

  a_byte_mask: assert property (
    (wr_cnt_ff != '0) |=> arr_byte_en_ff ==
      ~$past(s2_ff.byte_write_mask))
    else $error("byte enable does not follow mask");
endmodule : lpddr_command_decoder

// ==== pkg/lpddr_cmd_pkg.sv ====
package lpddr_cmd_pkg;
  // Core clock rate, used to turn times into cycle counts
  localparam int CLK_MHZ = 250;
  localparam int NBANKS = 4;
  localparam int BANK_W = 2;
  localparam int ADDR_W = 13;
  localparam int ROW_W = 13;
  localparam int AP_BIT = 10;
  localparam int DQ_W = 16;
  localparam int NBYTES = 2;
  localparam int CNT_W = 8;

  // Wait times in ns plus the burst length; plain defaults, tune per speed grade
  localparam int PRECHARGE_TIME_NS = 18;
  localparam int REFRESH_CYCLE_TIME_NS = 72;
  localparam int MODE_LOAD_WAIT_NS = 10;
  localparam int BURST_LEN = 4;

  // Least times round up to whole cycles
  localparam int PRE_CYC_DEF = (PRECHARGE_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int REF_CYC_DEF =
    (REFRESH_CYCLE_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int MRD_CYC_DEF = (MODE_LOAD_WAIT_NS * CLK_MHZ + 999) / 1000;
  localparam int BURST_CYC_DEF = BURST_LEN / 2;

  // Row, column and write strobe encodings with chip select low
  localparam logic [2:0] ENC_NOP = 3'h7;
  localparam logic [2:0] ENC_ACT = 3'h3;
  localparam logic [2:0] ENC_RD = 3'h5;
  localparam logic [2:0] ENC_WR = 3'h4;
  localparam logic [2:0] ENC_BST = 3'h6;
  localparam logic [2:0] ENC_PRE = 3'h2;
  localparam logic [2:0] ENC_REF = 3'h1;
  localparam logic [2:0] ENC_LMR = 3'h0;

  typedef enum logic [3:0] {
    CMD_NONE = 4'h0, CMD_ACT = 4'h1, CMD_RD = 4'h2, CMD_WR = 4'h3,
    CMD_PRE = 4'h4, CMD_PREA = 4'h5, CMD_BST = 4'h6, CMD_REF = 4'h7,
    CMD_SREF = 4'h8, CMD_DEEP_SLEEP = 4'h9, CMD_LMR = 4'hA
  } cmd_t;

  typedef enum logic [1:0] {
    MODE_RUN = 2'b00, MODE_SELF_REFRESH = 2'b01, MODE_DEEP_SLEEP = 2'b10
  } dev_mode_t;

  typedef enum logic [1:0] {
    BANK_IDLE = 2'b00, BANK_OPEN = 2'b01,
    BANK_AP_BURST = 2'b10, BANK_PRECHARGING = 2'b11
  } bank_state_t;

  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic cke;
    logic [BANK_W-1:0] bank_select;
    logic [ADDR_W-1:0] addr;
    logic [DQ_W-1:0] wr_data;
    logic [NBYTES-1:0] byte_write_mask;
  } cmd_pins_t;

  typedef struct packed {
    logic [BANK_W-1:0] bank;
    logic [ADDR_W-1:0] addr;
    logic auto_pre;
  } access_t;

  localparam cmd_pins_t PINS_IDLE = '{cs_n: 1'b1, ras_n: 1'b1,
    cas_n: 1'b1, we_n: 1'b1, cke: 1'b1, bank_select: '0, addr: '0,
    wr_data: '0, byte_write_mask: '1};
endpackage : lpddr_cmd_pkg

// ==== rtl/lpddr_bank_tracker.sv ====
`timescale 1ns/1ns
module lpddr_bank_tracker #(
  parameter int PRE_CYC = lpddr_cmd_pkg::PRE_CYC_DEF,
  parameter int BURST_CYC = lpddr_cmd_pkg::BURST_CYC_DEF
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic act,
  input wire logic access_go,
  input wire logic auto_pre,
  input wire logic pre,
  input wire logic [lpddr_cmd_pkg::ROW_W-1:0] row,
  output logic row_open,
  output logic idle,
  output logic [lpddr_cmd_pkg::ROW_W-1:0] open_row
);
  import lpddr_cmd_pkg::*;

  bank_state_t state_ff;
  logic [CNT_W-1:0] cnt_ff;
  logic [ROW_W-1:0] row_ff;
  logic [CNT_W-1:0] pre_len_ff;

  // Bank life: open, optional auto precharge after burst, precharge
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      state_ff <= BANK_IDLE;
      cnt_ff <= '0;
    end else begin
      unique case (state_ff)
        BANK_IDLE: begin
          if (act) begin
            state_ff <= BANK_OPEN;
          end
        end
        BANK_OPEN: begin
          if (pre) begin
            state_ff <= BANK_PRECHARGING;
            cnt_ff <= CNT_W'(PRE_CYC - 1);
          end else if (access_go && auto_pre) begin
            state_ff <= BANK_AP_BURST;
            cnt_ff <= CNT_W'(BURST_CYC - 1);
          end
        end
        BANK_AP_BURST: begin
          // Burst end starts the self-timed precharge
          if (cnt_ff == '0) begin
            state_ff <= BANK_PRECHARGING;
            cnt_ff <= CNT_W'(PRE_CYC - 1);
          end else begin
            cnt_ff <= cnt_ff - 1'b1;
          end
        end
        BANK_PRECHARGING: begin
          if (cnt_ff == '0) begin
            state_ff <= BANK_IDLE;
          end else begin
            cnt_ff <= cnt_ff - 1'b1;
          end
        end
      endcase
    end
  end

  // Row latched only when the bank opens
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      row_ff <= '0;
    end else if (state_ff == BANK_IDLE && act) begin
      row_ff <= row;
    end
  end

  assign row_open = (state_ff == BANK_OPEN);
  assign idle = (state_ff == BANK_IDLE);
  assign open_row = row_ff;

  // Helper: length of the precharge phase
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      pre_len_ff <= '0;
    end else begin
      pre_len_ff <= (state_ff == BANK_PRECHARGING) ?
        pre_len_ff + 1'b1 : '0;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  a_precharge_length: assert property (
    $fell(state_ff == BANK_PRECHARGING) |->
      pre_len_ff == CNT_W'(PRE_CYC) && state_ff == BANK_IDLE)
    else $error("precharge phase length wrong");

  a_ap_not_kept: assert property (
    (state_ff == BANK_OPEN && access_go && !auto_pre && !pre) |=>
      state_ff == BANK_OPEN)
    else $error("row closed without auto precharge");

  a_row_held: assert property (
    (state_ff == BANK_OPEN && !pre && !(access_go && auto_pre)) |=>
      state_ff == BANK_OPEN && $stable(row_ff))
    else $error("open row lost without precharge");
endmodule : lpddr_bank_tracker

// ==== verification/lpddr_ctrl_model.sv ====
`timescale 1ns/1ns
module lpddr_ctrl_model (
  input wire logic core_clk,
  output lpddr_cmd_pkg::cmd_pins_t pins
);
  import lpddr_cmd_pkg::*;
  // Pins start idle with clock enable high
  initial begin
    pins = PINS_IDLE;
  end
  // One command held over a single rising edge, changed at the fall
  task automatic send(input logic cs_n, input logic [2:0] enc,
    input logic cke, input logic [1:0] ba, input logic [12:0] a);
    @(negedge core_clk);
    pins.cs_n = cs_n;
    {pins.ras_n, pins.cas_n, pins.we_n} = enc;
    pins.cke = cke;
    pins.bank_select = ba;
    pins.addr = a;
    @(posedge core_clk);
  endtask : send
  // Write beat: data and its own mask ride under a no-operation
  task automatic beat(input logic [15:0] d, input logic [1:0] m);
    @(negedge core_clk);
    pins.cs_n = 1'b0;
    {pins.ras_n, pins.cas_n, pins.we_n} = ENC_NOP;
    pins.wr_data = d;
    pins.byte_write_mask = m;
    @(posedge core_clk);
  endtask : beat
  // Quiet spell; stale values flip so an old command cannot linger
  task automatic rest(input logic cke);
    @(negedge core_clk);
    pins.cs_n = 1'b1;
    {pins.ras_n, pins.cas_n, pins.we_n} = ENC_NOP;
    pins.cke = cke;
    pins.bank_select = ~pins.bank_select;
    pins.addr = ~pins.addr;
    pins.wr_data = ~pins.wr_data;
    pins.byte_write_mask = ~pins.byte_write_mask;
  endtask : rest
endmodule : lpddr_ctrl_model

// ==== verification/tb_lpddr_command_decoder.sv ====
`timescale 1ns/1ns
module tb_lpddr_command_decoder;
  import lpddr_cmd_pkg::*;
  // Short counts keep the run brief
  localparam int PRE_N = 5;
  localparam int REF_N = 6;
  localparam int MRD_N = 3;
  localparam int BL_N = 3;
  logic core_clk;
  logic resetn;
  cmd_pins_t pins;
  cmd_t cmd_ff;
  access_t access_ff;
  logic [NBANKS-1:0] row_open_ff;
  logic all_idle_ff, read_burst_ff, refresh_busy_ff, mode_load_ff;
  logic mode_busy_ff, array_powered_ff, arr_wr_en_ff;
  logic [1:0] read_bank_ff, mode_sel_ff, arr_wr_bank_ff, arr_byte_en_ff;
  logic [12:0] refresh_row_ff, mode_opcode_ff;
  logic [15:0] arr_wr_data_ff;
  dev_mode_t device_mode_ff;
  int fails = 0;
  int samples_checked = 0;
  int n;
  logic [1:0] b, b2;
  logic [12:0] a, r1;
  logic [15:0] d [BL_N];
  logic [1:0] m [BL_N];

  lpddr_ctrl_model ctrl_i (.core_clk(core_clk), .pins(pins));
  lpddr_command_decoder #(.PRE_CYC(PRE_N), .REF_CYC(REF_N),
    .MRD_CYC(MRD_N), .BURST_CYC(BL_N)) lpddr_command_decoder_i (
    .core_clk(core_clk), .resetn(resetn), .pins(pins), .cmd_ff(cmd_ff),
    .access_ff(access_ff), .row_open_ff(row_open_ff),
    .all_idle_ff(all_idle_ff), .read_burst_ff(read_burst_ff),
    .read_bank_ff(read_bank_ff), .refresh_busy_ff(refresh_busy_ff),
    .refresh_row_ff(refresh_row_ff), .mode_load_ff(mode_load_ff),
    .mode_sel_ff(mode_sel_ff), .mode_opcode_ff(mode_opcode_ff),
    .mode_busy_ff(mode_busy_ff), .device_mode_ff(device_mode_ff),
    .array_powered_ff(array_powered_ff), .arr_wr_en_ff(arr_wr_en_ff),
    .arr_wr_bank_ff(arr_wr_bank_ff), .arr_wr_data_ff(arr_wr_data_ff),
    .arr_byte_en_ff(arr_byte_en_ff));

  // 250 MHz core clock
  initial begin
    core_clk = 1'b0;
  end
  // Runs free so no burst is ever cut by a stopped clock
  always #2 core_clk = ~core_clk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : wrap_up

  // Sample just after an edge, once its updates have landed
  task automatic after(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask : after

  // Issue one command, then look at the decode two edges later
  task automatic cmd(input logic cs_n, input logic [2:0] enc,
    input logic cke, input logic [1:0] ba, input logic [12:0] a,
    input cmd_t exp);
    ctrl_i.send(cs_n, enc, cke, ba, a);
    ctrl_i.rest(cke);
    after(2);
    check(cmd_ff, exp);
    if (exp != CMD_NONE) begin
      check(access_ff, {ba, a, a[AP_BIT]});
    end
  endtask : cmd

  // Length of a busy level already high; the bound stops a stuck flag
  task automatic busy_len(input bit mode, input int exp);
    int k;
    k = 0;
    while ((mode ? mode_busy_ff : refresh_busy_ff) === 1'b1 && k < 99) begin
      k++;
      after(1);
    end
    check(k, exp);
    if (k >= 99) wrap_up;
  endtask : busy_len

  // Write burst with random data, first mask zero then random masks, beats checked at the array
  task automatic wr_burst(input logic [1:0] ba, input logic [12:0] a);
    ctrl_i.send(1'b0, ENC_WR, 1'b1, ba, a);
    for (int i = 0; i < BL_N; i++) begin
      d[i] = 16'($urandom);
      m[i] = (i == 0) ? 2'h0 : 2'($urandom);
      ctrl_i.beat(d[i], m[i]);
      // The command pulse stands only in the cycle after the second beat
      if (i == 1) begin
        #1;
        check(cmd_ff, CMD_WR);
      end
    end
    ctrl_i.rest(1'b1);
    // First beat already stands at the array port here
    for (int i = 0; i < BL_N; i++) begin
      check({arr_wr_en_ff, arr_wr_bank_ff, arr_wr_data_ff, arr_byte_en_ff},
        {1'b1, ba, d[i], ~m[i]});
      after(1);
    end
    check(arr_wr_en_ff, 1'b0);
  endtask : wr_burst

  initial begin
    resetn = 1'b0;
    void'($urandom(8));
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    resetn = 1'b1;
    after(1);
    check({cmd_ff, row_open_ff, all_idle_ff, device_mode_ff,
      array_powered_ff}, {CMD_NONE, 4'h0, 1'b1, MODE_RUN, 1'b1});
    $display("test reset done");
    cmd(1'b1, 3'($urandom), 1'b1, 2'($urandom), 13'($urandom),
      CMD_NONE);
    cmd(1'b0, ENC_NOP, 1'b1, 2'($urandom), 13'($urandom), CMD_NONE);
    b = 2'($urandom);
    b2 = b ^ 2'h1;
    cmd(1'b0, ENC_ACT, 1'b1, b, 13'($urandom), CMD_ACT);
    cmd(1'b0, ENC_ACT, 1'b1, b2, 13'($urandom), CMD_ACT);
    after(2);
    check(row_open_ff[b] & row_open_ff[b2], 1'b1);
    $display("test activate done");
    // Read cut short by burst stop on the very next edge
    a = 13'($urandom) & 13'h1BFF;
    ctrl_i.send(1'b0, ENC_RD, 1'b1, b, a);
    ctrl_i.send(1'b0, ENC_BST, 1'b1, 2'($urandom), 13'($urandom));
    ctrl_i.rest(1'b1);
    after(1);
    check(cmd_ff, CMD_RD);
    check({read_burst_ff, read_bank_ff, access_ff}, {1'b1, b, b, a, 1'b0});
    after(1);
    check(cmd_ff, CMD_BST);
    after(1);
    check({read_burst_ff, row_open_ff[b]}, 2'h1);
    $display("test burst stop done");
    wr_burst(b, 13'($urandom) & 13'h1BFF);
    check(row_open_ff[b], 1'b1);
    wr_burst(b, 13'($urandom) | 13'h0400);
    n = 0;
    while (row_open_ff[b] !== 1'b0 && n < 40) begin
      n++;
      after(1);
    end
    check(row_open_ff[b2] && n < 40, 1'b1);
    if (n >= 40) wrap_up;
    after(PRE_N + 2);
    cmd(1'b0, ENC_ACT, 1'b1, b, 13'($urandom), CMD_ACT);
    cmd(1'b0, ENC_RD, 1'b1, b, 13'($urandom) & 13'h1BFF, CMD_RD);
    after(12);
    check(row_open_ff[b], 1'b1);
    $display("test write done");
    cmd(1'b0, ENC_PRE, 1'b1, b, 13'($urandom) & 13'h1BFF, CMD_PRE);
    after(2);
    check({row_open_ff[b], row_open_ff[b2]}, 2'h1);
    after(PRE_N);
    cmd(1'b0, ENC_PRE, 1'b1, 2'($urandom), 13'($urandom) | 13'h0400,
      CMD_PREA);
    after(2);
    check(row_open_ff, 4'h0);
    after(PRE_N + 2);
    check(all_idle_ff, 1'b1);
    $display("test precharge done");
    cmd(1'b0, ENC_REF, 1'b1, 2'($urandom), 13'($urandom), CMD_REF);
    r1 = refresh_row_ff;
    busy_len(1'b0, REF_N);
    after(1);
    check(all_idle_ff, 1'b1);
    cmd(1'b0, ENC_REF, 1'b1, 2'($urandom), 13'($urandom), CMD_REF);
    check(refresh_row_ff !== r1, 1'b1);
    busy_len(1'b0, REF_N);
    $display("test refresh done");
    b = 2'($urandom);
    a = 13'($urandom);
    cmd(1'b0, ENC_LMR, 1'b1, b, a, CMD_LMR);
    check({mode_load_ff, mode_sel_ff, mode_opcode_ff}, {1'b1, b, a});
    busy_len(1'b1, MRD_N);
    $display("test mode load done");
    cmd(1'b0, ENC_REF, 1'b0, b, a, CMD_SREF);
    check(device_mode_ff, MODE_SELF_REFRESH);
    cmd(1'b0, ENC_ACT, 1'b0, b, a, CMD_NONE);
    ctrl_i.rest(1'b1);
    after(4);
    check(device_mode_ff, MODE_RUN);
    // Refresh pattern resumes straight after the exit
    cmd(1'b0, ENC_REF, 1'b1, b, a, CMD_REF);
    busy_len(1'b0, REF_N);
    $display("test self refresh done");
    cmd(1'b0, ENC_BST, 1'b0, b, a, CMD_DEEP_SLEEP);
    check({device_mode_ff, array_powered_ff}, {MODE_DEEP_SLEEP, 1'b0});
    ctrl_i.rest(1'b1);
    after(4);
    check({device_mode_ff, array_powered_ff}, {MODE_RUN, 1'b1});
    $display("test deep sleep done");
    wrap_up;
  end
endmodule : tb_lpddr_command_decoder
